// >>> led_pat_pkg.sv
// Purpose: Shared constants and types for the LED pattern level engine
// Assumes: 20 MHz system clock, APB register access
// Notes: Hold times count in 1.024 ms sub-ticks
package led_pat_pkg;
	localparam int NBANK = 4;
	localparam int CLK_PERIOD_NS = 50;
	localparam int SUB_TICK_NS = 1024000;
	localparam int SUB_TICK_CYC = SUB_TICK_NS / CLK_PERIOD_NS;
	localparam int SUB_TICK_US = SUB_TICK_NS / 1000;
	localparam int STEP_SHORT_US = 16384;
	localparam int STEP_MID_US = 131072;
	localparam int STEP_LONG_US = 524288;
	localparam logic [19:0] SHORT_ST = 20'(STEP_SHORT_US / SUB_TICK_US);
	localparam logic [19:0] MID_ST = 20'(STEP_MID_US / SUB_TICK_US);
	localparam logic [19:0] LONG_ST = 20'(STEP_LONG_US / SUB_TICK_US);
	localparam logic [19:0] RAMP_BASE = 20'h00010;
	localparam logic [7:0] SHORT_LAST = 8'h3c;
	localparam logic [7:0] CODE_TOP = 8'h7f;
	localparam logic [15:0] LIN_GAIN = 16'h0101;
	localparam logic [11:0] EXP_LOW_K = 12'h096;
	localparam logic [11:0] EXP_HIGH_K = 12'h0a0;
	localparam logic [11:0] EXP_HIGH_OFS = 12'h030;
	localparam logic [5:0] UP_PERIODS = 6'h03;
	localparam logic [5:0] DOWN_BASE = 6'h06;
	// Register byte offsets
	localparam logic [11:0] REG_AMB_CTRL = 12'h000;
	localparam logic [11:0] REG_SCALE = 12'h004;
	localparam logic [11:0] REG_ZONE_INFO = 12'h008;
	localparam logic [11:0] REG_STATUS = 12'h00c;
	localparam logic [11:0] BANK_BASE = 12'h040;
	localparam logic [11:0] BANK_END = 12'h0c0;
	localparam logic [4:0] BK_CFG = 5'h00;
	localparam logic [4:0] BK_DELAY = 5'h04;
	localparam logic [4:0] BK_RAMP = 5'h08;
	localparam logic [4:0] BK_THIGH = 5'h0c;
	localparam logic [4:0] BK_TLOW = 5'h10;
	localparam logic [4:0] BK_LOW = 5'h14;
	localparam logic [4:0] BK_HIGH = 5'h18;
	// Field positions and reset values
	localparam int CFG_EXP = 0;
	localparam int CFG_PWM = 1;
	localparam int CFG_PAT_EN = 3;
	localparam int CFG_FS_LSB = 4;
	localparam int AMB_EN = 0;
	localparam int AMB_ALG_LSB = 1;
	localparam int AMB_DD_LSB = 4;
	localparam int ZI_INT = 0;
	localparam int ZI_ZONE_LSB = 4;
	localparam int ZI_FLAG = 8;
	localparam logic [8:0] CFG_RST = 9'h130;
	typedef enum logic [5:0] {
		PS_IDLE = 6'h01, PS_DELAY = 6'h02, PS_RISE = 6'h04,
		PS_HIGH = 6'h08, PS_FALL = 6'h10, PS_LOW = 6'h20
	} pat_state_t;
	typedef enum logic [1:0] {
		ALG_DIRECT = 2'h0, ALG_UP_ONLY = 2'h1, ALG_DOWN_DELAY = 2'h2
	} zone_alg_t;
	// 2^(-i/16) in Q16
	localparam logic [15:0] EXP2_FRAC [16] = '{
		16'hffff, 16'hf525, 16'heac1, 16'he0cd, 16'hd745, 16'hce25, 16'hc567, 16'hbd09,
		16'hb505, 16'had58, 16'ha5ff, 16'h9ef5, 16'h9838, 16'h91c4, 16'h8b96, 16'h85ab};
endpackage

// >>> led_pattern_level_engine.sv
// Purpose: Four-bank LED pattern sequencer with level mapping and zone scaling
// Assumes: APB3 slave, synchronous inputs, single clock domain
// Notes: SINK_LEVEL is set point in 1/65536 of the largest full-scale current
// Summary of operation
// - Low-hold codes 0x00-0x3C add 16.384 ms per code, 61 codes
// - Low-hold codes 0x3D-0x7F add 524.288 ms per code onward
// - Low hold drives low set point, high hold drives high set point
// - Linear low point: full scale times code over 255 times duty
// - Exponential low point: full scale times 0.85 power curve times duty
// - Exponential high point: full scale times 0.862 power curve times duty
// - High point uses bank brightness code, linear is code over 255
// - Duty factor applies only when bank PWM input enabled
// - Zone tracking uses direct, up-only and down-delay variants
// - Codes scaled by active zone 4-bit factor, 1/16 to 16/16
// - Programmed codes are scaled, never replaced by zone targets
// - One scale factor set shared by all pattern generators
// - Banks use pattern scalers only while their pattern is enabled
// - Zone info bit 0 selects open-drain interrupt use of pin
// - In interrupt mode pin pulls low on zone change while enabled
// - Reading zone info register releases the interrupt pin
// - Writing pattern enable bit 3 starts the delay phase
// - Start delay steps 16.384 ms then 131.072 ms above 0x3C
// - High hold steps 16.384 ms then 131.072 ms above 0x3C
// - Separate rise and fall selects, eight ramp durations each
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module led_pattern_level_engine #(
	parameter int SUB_TICK = led_pat_pkg::SUB_TICK_CYC
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic NRST,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output var logic [31:0] PRDATA,
	output var logic PREADY,
	output var logic PSLVERR,
	// Ambient light zone input and duty
	input wire logic ZONE_STROBE,
	input wire logic [2:0] ZONE,
	input wire logic [7:0] PWM_DUTY,
	// Sink levels
	output var logic [led_pat_pkg::NBANK-1:0][15:0] SINK_LEVEL,
	output var logic [led_pat_pkg::NBANK-1:0] PAT_ACTIVE,
	// Zone change pin, open drain
	output var logic ZONE_IRQ_N_O,
	output var logic ZONE_IRQ_N_OE
);
	import led_pat_pkg::*;

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	function automatic logic [19:0] hold_len(input logic [7:0] code, input logic [19:0] step);
		logic [7:0] c;
		c = (code > CODE_TOP) ? CODE_TOP : code;
		if (c <= SHORT_LAST) begin
			return 20'({12'h000, c} + 20'h00001) * SHORT_ST;
		end
		return 20'({12'h000, SHORT_LAST} + 20'h00001) * SHORT_ST
			+ 20'({12'h000, c - SHORT_LAST}) * step;
	endfunction

	function automatic logic [15:0] exp_frac(input logic [7:0] code, input logic [11:0] k,
		input logic [11:0] ofs);
		logic [19:0] t;
		t = ({12'h000, 8'hff - code} * {8'h00, k}) + {8'h00, ofs};
		return EXP2_FRAC[t[11:8]] >> t[16:12];
	endfunction

	function automatic logic [15:0] set_point(input logic [7:0] code, input logic hi,
		input logic [8:0] cfg, input logic [7:0] duty);
		logic [15:0] f;
		logic [31:0] p;
		logic [21:0] s;
		if (cfg[CFG_EXP]) begin
			f = hi ? exp_frac(code, EXP_HIGH_K, EXP_HIGH_OFS) : exp_frac(code, EXP_LOW_K, 12'h000);
		end else begin
			f = {8'h00, code} * LIN_GAIN;
		end
		p = ({16'h0000, f} * {24'h000000, duty}) * {16'h0000, LIN_GAIN};
		if (cfg[CFG_PWM]) begin
			f = p[31:16];
		end
		s = {6'h00, f} * {16'h0000, {1'b0, cfg[CFG_FS_LSB +: 5]} + 6'h01};
		return s[20:5];
	endfunction

	function automatic logic [15:0] interp(input logic [15:0] a, input logic [15:0] b,
		input logic [3:0] stage);
		logic [19:0] d;
		if (b >= a) begin
			d = {4'h0, b - a} * {16'h0000, stage};
			return a + d[19:4];
		end
		d = {4'h0, a - b} * {16'h0000, stage};
		return a - d[19:4];
	endfunction

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [8:0] amb_ctrl_q;
	logic [31:0] scale_q;
	logic int_mode_q;
	logic flag_q;
	logic [8:0] cfg_q [NBANK];
	logic [7:0] delay_q [NBANK];
	logic [6:0] ramp_q [NBANK];
	logic [7:0] thigh_q [NBANK];
	logic [7:0] tlow_q [NBANK];
	logic [7:0] low_code_q [NBANK];
	logic [7:0] high_code_q [NBANK];
	logic [2:0] act_q;
	logic [2:0] meas_q;
	logic [5:0] run_q;
	logic [19:0] pre_q;
	logic sub_tick;
	logic [15:0] lvl_w [NBANK];
	logic [NBANK-1:0] run_w;
	logic [31:0] rdata;
	logic addr_ok;
	logic wr_done;
	logic zi_rd;
	logic zchg;
	logic amb_en;
	logic [3:0] scale_n;
	logic [11:0] boff;
	logic [1:0] bidx;

	assign amb_en = amb_ctrl_q[AMB_EN];
	assign scale_n = scale_q[{act_q, 2'b00} +: 4];
	assign boff = PADDR - BANK_BASE;
	assign bidx = boff[6:5];
	assign wr_done = PSEL & PENABLE & PREADY & PWRITE & ~PSLVERR;
	assign zi_rd = PSEL & PENABLE & PREADY & ~PWRITE & (PADDR == REG_ZONE_INFO);
	assign zchg = ZONE_STROBE & amb_en & (ZONE != meas_q);

	// Read mux and address decode
	always_comb begin
		rdata = 32'h00000000;
		addr_ok = 1'b1;
		if (PADDR[1:0] != 2'b00) begin
			addr_ok = 1'b0;
		end else if (PADDR == REG_AMB_CTRL) begin
			rdata[8:0] = amb_ctrl_q;
		end else if (PADDR == REG_SCALE) begin
			rdata = scale_q;
		end else if (PADDR == REG_ZONE_INFO) begin
			rdata[ZI_INT] = int_mode_q;
			rdata[ZI_ZONE_LSB +: 3] = act_q;
			rdata[ZI_FLAG] = flag_q;
		end else if (PADDR == REG_STATUS) begin
			rdata[NBANK-1:0] = run_w;
			rdata[6:4] = act_q;
		end else if (PADDR >= BANK_BASE && PADDR < BANK_END) begin
			case (boff[4:0])
				BK_CFG: rdata[8:0] = cfg_q[bidx];
				BK_DELAY: rdata[7:0] = delay_q[bidx];
				BK_RAMP: rdata[6:0] = ramp_q[bidx];
				BK_THIGH: rdata[7:0] = thigh_q[bidx];
				BK_TLOW: rdata[7:0] = tlow_q[bidx];
				BK_LOW: rdata[7:0] = low_code_q[bidx];
				BK_HIGH: rdata[7:0] = high_code_q[bidx];
				default: addr_ok = 1'b0;
			endcase
		end else begin
			addr_ok = 1'b0;
		end
	end

	// ----------------------------------------
	// APB slave, one wait state
	// ----------------------------------------
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA <= 32'h00000000;
		end else begin
			PREADY <= PSEL & PENABLE & ~PREADY;
			PSLVERR <= PSEL & PENABLE & ~PREADY & ~addr_ok;
			PRDATA <= (PSEL & PENABLE & ~PREADY & ~PWRITE) ? rdata : 32'h00000000;
		end
	end

	// Register writes
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			amb_ctrl_q <= 9'h000;
			scale_q <= 32'hffffffff;
			int_mode_q <= 1'b0;
			for (int i = 0; i < NBANK; i++) begin
				cfg_q[i] <= CFG_RST;
				delay_q[i] <= 8'h00;
				ramp_q[i] <= 7'h00;
				thigh_q[i] <= 8'h00;
				tlow_q[i] <= 8'h00;
				low_code_q[i] <= 8'h00;
				high_code_q[i] <= 8'h00;
			end
		end else if (wr_done) begin
			if (PADDR == REG_AMB_CTRL) amb_ctrl_q <= PWDATA[8:0];
			if (PADDR == REG_SCALE) scale_q <= PWDATA;
			if (PADDR == REG_ZONE_INFO) int_mode_q <= PWDATA[ZI_INT];
			if (PADDR >= BANK_BASE && PADDR < BANK_END) begin
				case (boff[4:0])
					BK_CFG: cfg_q[bidx] <= PWDATA[8:0];
					BK_DELAY: delay_q[bidx] <= PWDATA[7:0];
					BK_RAMP: ramp_q[bidx] <= PWDATA[6:0];
					BK_THIGH: thigh_q[bidx] <= PWDATA[7:0];
					BK_TLOW: tlow_q[bidx] <= PWDATA[7:0];
					BK_LOW: low_code_q[bidx] <= PWDATA[7:0];
					BK_HIGH: high_code_q[bidx] <= PWDATA[7:0];
					default: ;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Zone tracking and change interrupt
	// ----------------------------------------
	// Active zone follows averaged zone per selected variant
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			act_q <= 3'h0;
			meas_q <= 3'h0;
			run_q <= 6'h00;
		end else if (ZONE_STROBE && amb_en) begin
			meas_q <= ZONE;
			if (ZONE == act_q) begin
				run_q <= 6'h00;
			end else if (ZONE < act_q && zone_alg_t'(amb_ctrl_q[AMB_ALG_LSB +: 2]) == ALG_UP_ONLY) begin
				run_q <= 6'h00;
			end else if (run_q + 6'h01 >= ((ZONE < act_q &&
				zone_alg_t'(amb_ctrl_q[AMB_ALG_LSB +: 2]) == ALG_DOWN_DELAY) ?
				DOWN_BASE + {1'b0, amb_ctrl_q[AMB_DD_LSB +: 5]} : UP_PERIODS)) begin
				act_q <= ZONE;
				run_q <= 6'h00;
			end else begin
				run_q <= run_q + 6'h01;
			end
		end
	end

	// Sticky change flag, set wins over read clear
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			flag_q <= 1'b0;
			ZONE_IRQ_N_OE <= 1'b0;
		end else begin
			flag_q <= zchg | (flag_q & ~zi_rd);
			ZONE_IRQ_N_OE <= int_mode_q & (zchg | (flag_q & ~zi_rd));
		end
	end

	// Pin only ever pulls low
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			ZONE_IRQ_N_O <= 1'b0;
		end else begin
			ZONE_IRQ_N_O <= 1'b0;
		end
	end

	// ----------------------------------------
	// Sub-tick prescaler, 1.024 ms
	// ----------------------------------------
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			pre_q <= 20'h00000;
		end else begin
			pre_q <= sub_tick ? 20'h00000 : pre_q + 20'h00001;
		end
	end
	assign sub_tick = (pre_q == 20'(SUB_TICK - 1));

	// ----------------------------------------
	// Pattern generators
	// ----------------------------------------
	for (genvar b = 0; b < NBANK; b++) begin : g_bank
		pat_state_t st_q;
		pat_state_t nxt_st;
		logic [19:0] cnt_q;
		logic [19:0] nxt_len;
		logic [19:0] ramp_len;
		logic [2:0] rsel;
		logic [3:0] stage;
		logic [12:0] lo_scaled;
		logic [12:0] hi_scaled;
		logic [7:0] lo_code;
		logic [7:0] hi_code;
		logic [15:0] lo_lvl;
		logic [15:0] hi_lvl;
		logic en;
		logic scale_on;

		assign en = cfg_q[b][CFG_PAT_EN];
		assign scale_on = en & amb_en;
		assign lo_scaled = {5'h00, low_code_q[b]} * {8'h00, {1'b0, scale_n} + 5'h01};
		assign hi_scaled = {5'h00, high_code_q[b]} * {8'h00, {1'b0, scale_n} + 5'h01};
		assign lo_code = scale_on ? lo_scaled[11:4] : low_code_q[b];
		assign hi_code = scale_on ? hi_scaled[11:4] : high_code_q[b];
		assign lo_lvl = set_point(lo_code, 1'b0, cfg_q[b], PWM_DUTY);
		assign hi_lvl = set_point(hi_code, 1'b1, cfg_q[b], PWM_DUTY);
		assign rsel = (st_q == PS_RISE) ? ramp_q[b][2:0] : ramp_q[b][6:4];
		assign ramp_len = RAMP_BASE << rsel;
		assign stage = 4'((ramp_len - cnt_q) >> rsel);
		assign run_w[b] = (st_q != PS_IDLE);

		// Next phase and its length
		always_comb begin
			case (st_q)
				PS_IDLE: begin
					nxt_st = PS_DELAY;
					nxt_len = hold_len(delay_q[b], MID_ST);
				end
				PS_DELAY, PS_LOW: begin
					nxt_st = PS_RISE;
					nxt_len = RAMP_BASE << ramp_q[b][2:0];
				end
				PS_RISE: begin
					nxt_st = PS_HIGH;
					nxt_len = hold_len(thigh_q[b], MID_ST);
				end
				PS_HIGH: begin
					nxt_st = PS_FALL;
					nxt_len = RAMP_BASE << ramp_q[b][6:4];
				end
				PS_FALL: begin
					nxt_st = PS_LOW;
					nxt_len = hold_len(tlow_q[b], LONG_ST);
				end
				default: begin
					nxt_st = PS_IDLE;
					nxt_len = 20'h00001;
				end
			endcase
		end

		// Phase sequencer
		always_ff @(posedge CLK or negedge NRST) begin
			if (!NRST) begin
				st_q <= PS_IDLE;
				cnt_q <= 20'h00000;
			end else if (!en) begin
				st_q <= PS_IDLE;
				cnt_q <= 20'h00000;
			end else if (st_q == PS_IDLE) begin
				st_q <= nxt_st;
				cnt_q <= nxt_len;
			end else if (sub_tick) begin
				if (cnt_q <= 20'h00001) begin
					st_q <= nxt_st;
					cnt_q <= nxt_len;
				end else begin
					cnt_q <= cnt_q - 20'h00001;
				end
			end
		end

		// Level for the current phase
		always_comb begin
			case (st_q)
				PS_DELAY, PS_LOW: lvl_w[b] = lo_lvl;
				PS_HIGH: lvl_w[b] = hi_lvl;
				PS_RISE: lvl_w[b] = interp(lo_lvl, hi_lvl, stage);
				PS_FALL: lvl_w[b] = interp(hi_lvl, lo_lvl, stage);
				default: lvl_w[b] = 16'h0000;
			endcase
		end
	end

	// Registered sink outputs
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			SINK_LEVEL <= '0;
			PAT_ACTIVE <= '0;
		end else begin
			for (int i = 0; i < NBANK; i++) begin
				SINK_LEVEL[i] <= lvl_w[i];
				PAT_ACTIVE[i] <= cfg_q[i][CFG_PAT_EN];
			end
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);

	property p_low_hold;
		$rose(g_bank[0].st_q == PS_LOW) |-> g_bank[0].cnt_q == hold_len($past(tlow_q[0]), LONG_ST);
	endproperty
	a_low_hold: assert property (p_low_hold) else $error("low hold length wrong");
	property p_delay_len;
		$rose(g_bank[0].st_q == PS_DELAY) |-> g_bank[0].cnt_q == hold_len($past(delay_q[0]), MID_ST);
	endproperty
	a_delay_len: assert property (p_delay_len) else $error("delay length wrong");
	property p_high_len;
		$rose(g_bank[0].st_q == PS_HIGH) |-> g_bank[0].cnt_q == hold_len($past(thigh_q[0]), MID_ST);
	endproperty
	a_high_len: assert property (p_high_len) else $error("high hold length wrong");
	property p_rise_len;
		$rose(g_bank[0].st_q == PS_RISE) |-> g_bank[0].cnt_q == (RAMP_BASE << $past(ramp_q[0][2:0]));
	endproperty
	a_rise_len: assert property (p_rise_len) else $error("rise length wrong");
	property p_order;
		(g_bank[0].st_q == PS_HIGH ##1 g_bank[0].st_q != PS_HIGH && g_bank[0].st_q != PS_IDLE)
			|-> g_bank[0].st_q == PS_FALL;
	endproperty
	a_order: assert property (p_order) else $error("phase order wrong");
	property p_low_level;
		g_bank[0].st_q == PS_LOW |=> SINK_LEVEL[0] == $past(g_bank[0].lo_lvl);
	endproperty
	a_low_level: assert property (p_low_level) else $error("low level not driven");
	property p_linear;
		(g_bank[0].st_q == PS_HIGH && cfg_q[0][CFG_EXP +: 2] == 2'b00 && !g_bank[0].scale_on
			&& cfg_q[0][CFG_FS_LSB +: 5] == 5'h1f) |=> SINK_LEVEL[0] == {2{$past(high_code_q[0])}};
	endproperty
	a_linear: assert property (p_linear) else $error("linear level wrong");
	property p_scale;
		(g_bank[0].scale_on && scale_n == 4'h7) |-> g_bank[0].lo_code == {1'b0, low_code_q[0][7:1]};
	endproperty
	a_scale: assert property (p_scale) else $error("scale factor wrong");
	property p_irq_mode;
		!int_mode_q |=> !ZONE_IRQ_N_OE;
	endproperty
	a_irq_mode: assert property (p_irq_mode) else $error("pin pulled outside mode");
	property p_irq_set;
		(int_mode_q && zchg) |=> ZONE_IRQ_N_OE ##1 (ZONE_IRQ_N_OE || $past(zi_rd));
	endproperty
	a_irq_set: assert property (p_irq_set) else $error("zone change not flagged");
	property p_irq_clr;
		(zi_rd && !zchg) |=> !ZONE_IRQ_N_OE && !flag_q;
	endproperty
	a_irq_clr: assert property (p_irq_clr) else $error("read did not release pin");
	property p_start;
		(g_bank[0].st_q == PS_IDLE && g_bank[0].en) |=> g_bank[0].st_q == PS_DELAY;
	endproperty
	a_start: assert property (p_start) else $error("pattern did not start");

	c_full_cycle: cover property (g_bank[0].st_q == PS_LOW ##1 g_bank[0].st_q == PS_RISE);
	c_irq: cover property (zchg && int_mode_q ##[1:20] zi_rd);
	c_scaled: cover property (g_bank[1].scale_on && g_bank[1].st_q == PS_HIGH);
endmodule
`default_nettype wire

// >>> led_sink_model.sv
// Purpose: Behavioural LED current sinks and zone pin pull-up
// Assumes: Sinks follow set points with no lag
// Notes: Released pin rests high through the pull-up
`timescale 1ns/1ps
`default_nettype none
module led_sink_model import led_pat_pkg::*; (
	// Set points from the engine
	input wire logic [led_pat_pkg::NBANK-1:0][15:0] level,
	input wire logic [led_pat_pkg::NBANK-1:0] pat_on,
	// Open-drain pin drive
	input wire logic irq_o,
	input wire logic irq_oe,
	output logic irq_line,
	output logic [led_pat_pkg::NBANK-1:0] lit
);
	// ----
	// Pin and sinks
	// ----
	// Pull-up wins unless the engine sinks the pin
	assign irq_line = irq_oe ? irq_o : 1'b1;
	// Sink conducts while its pattern is on and its set point is non-zero
	always_comb begin
		for (int i = 0; i < NBANK; i++) begin
			lit[i] = pat_on[i] & (level[i] != 16'h0000);
		end
	end
endmodule
`default_nettype wire

// >>> led_pattern_level_engine_test.sv
// Purpose: Self-checking bench for the LED pattern level engine
// Assumes: Sub-tick shortened to 4 cycles, APB master in bench
// Notes: Full-scale code 0x1f gives unit scale on set points
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin err_count++; \
	$display("[ERR] %s exp %h got %h", nm, ex, got); end end
module led_pattern_level_engine_test;
	import led_pat_pkg::*;
	localparam int ST = 4;
	logic CLK, NRST, PSEL, PENABLE, PWRITE, ZONE_STROBE, PREADY, PSLVERR;
	logic [11:0] PADDR;
	logic [31:0] PWDATA, PRDATA;
	logic [2:0] ZONE;
	logic [7:0] PWM_DUTY;
	logic [NBANK-1:0][15:0] SINK_LEVEL;
	logic [NBANK-1:0] PAT_ACTIVE, lit;
	logic ZONE_IRQ_N_O, ZONE_IRQ_N_OE, irq_line;
	int err_count, check_count;
	// ----
	// Clock, design and sink model
	// ----
	always #25 CLK = ~CLK;
	led_pattern_level_engine #(.SUB_TICK(ST)) led_pattern_level_engine_inst (.CLK(CLK),
		.NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
		.PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.ZONE_STROBE(ZONE_STROBE), .ZONE(ZONE), .PWM_DUTY(PWM_DUTY),
		.SINK_LEVEL(SINK_LEVEL), .PAT_ACTIVE(PAT_ACTIVE), .ZONE_IRQ_N_O(ZONE_IRQ_N_O),
		.ZONE_IRQ_N_OE(ZONE_IRQ_N_OE));
	led_sink_model led_sink_model_inst (.level(SINK_LEVEL), .pat_on(PAT_ACTIVE),
		.irq_o(ZONE_IRQ_N_O), .irq_oe(ZONE_IRQ_N_OE), .irq_line(irq_line), .lit(lit));
	// ----
	// Bus and helper tasks
	// ----
	// One APB transfer, held until PREADY is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		@(posedge CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do begin
			@(posedge CLK);
		end while (PREADY !== 1'b1);
		q = PRDATA;
		e = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	function automatic logic [11:0] ba(input int b, input logic [4:0] o);
		return BANK_BASE + 12'(b * 32) + {7'h00, o};
	endfunction
	// Program one bank, enable bit last
	task automatic prog(input int b, input logic [8:0] cfg, input logic [7:0] dly,
			input logic [7:0] tlo, input logic [7:0] lo, input logic [7:0] hi);
		wr(ba(b, BK_DELAY), {24'h0, dly});
		wr(ba(b, BK_RAMP), 32'h0);
		wr(ba(b, BK_THIGH), 32'h0);
		wr(ba(b, BK_TLOW), {24'h0, tlo});
		wr(ba(b, BK_LOW), {24'h0, lo});
		wr(ba(b, BK_HIGH), {24'h0, hi});
		wr(ba(b, BK_CFG), {23'h0, cfg});
	endtask
	task automatic wait_lvl(input int b, input logic [15:0] v, input int lim, output int n);
		n = 0;
		while (SINK_LEVEL[b] !== v && n < lim) begin
			@(posedge CLK);
			n++;
		end
	endtask
	task automatic strobe(input logic [2:0] z, input int n);
		repeat (n) begin
			@(posedge CLK);
			ZONE_STROBE <= 1'b1;
			ZONE <= z;
			@(posedge CLK);
			ZONE_STROBE <= 1'b0;
		end
		repeat (3) @(posedge CLK);
	endtask
	function automatic logic near(input logic [15:0] v, input int e);
		return (int'(v) >= e - e / 10) && (int'(v) <= e + e / 10);
	endfunction
	// ----
	// Scenarios
	// ----
	task automatic t_reset;
		logic [31:0] q;
		logic e;
		apb(1'b0, ba(0, BK_CFG), 32'h0, q, e);
		`CHK("cfg_rst", {23'h0, CFG_RST}, q)
		apb(1'b0, REG_SCALE, 32'h0, q, e);
		`CHK("scale_rst", 32'hffffffff, q)
		apb(1'b0, 12'h010, 32'h0, q, e);
		`CHK("bad_err", 1'b1, e)
		`CHK("bad_rd", 32'h0, q)
		`CHK("pin_idle", 1'b1, irq_line)
	endtask
	// Long delay and long low hold, linear levels
	task automatic t_linear;
		int n;
		prog(0, 9'h1f8, 8'h3d, 8'h3d, 8'h40, 8'hff);
		repeat (8) @(posedge CLK);
		`CHK("pat_on", 1'b1, PAT_ACTIVE[0])
		`CHK("delay_lvl", 16'h4040, SINK_LEVEL[0])
		`CHK("sink_lit", 1'b1, lit[0])
		wait_lvl(0, 16'hffff, 6000, n);
		`CHK("delay_len", 1'b1, n >= 4400 && n <= 4520)
		`CHK("high_lvl", 16'hffff, SINK_LEVEL[0])
		wait_lvl(0, 16'h4040, 400, n);
		`CHK("fall_done", 1'b1, n < 400)
		n = 0;
		while (SINK_LEVEL[0] === 16'h4040 && n < 7000) begin
			@(posedge CLK);
			n++;
		end
		`CHK("low_len", 1'b1, n >= 5940 && n <= 6040)
		wr(ba(0, BK_CFG), 32'h1f0);
		repeat (4) @(posedge CLK);
		`CHK("stop_lvl", 16'h0000, SINK_LEVEL[0])
		`CHK("pat_off", 1'b0, PAT_ACTIVE[0])
	endtask
	// Duty 0x80 applied with PWM enabled
	task automatic t_pwm;
		int n;
		prog(1, 9'h1fa, 8'h00, 8'h00, 8'h40, 8'hff);
		wait_lvl(1, 16'((32'h4040 * 32'h80 * 32'd257) >> 16), 40, n);
		`CHK("pwm_low", 1'b1, n < 40)
		wait_lvl(1, 16'((32'hffff * 32'h80 * 32'd257) >> 16), 300, n);
		`CHK("pwm_high", 1'b1, n < 300)
		wr(ba(1, BK_CFG), 32'h1f0);
	endtask
	task automatic t_exp;
		prog(2, 9'h1f9, 8'h00, 8'h00, 8'hbf, 8'h7f);
		repeat (10) @(posedge CLK);
		`CHK("exp_low", 1'b1, near(SINK_LEVEL[2], 12902))
		repeat (150) @(posedge CLK);
		`CHK("exp_high", 1'b1, near(SINK_LEVEL[2], 2052))
		wr(ba(2, BK_CFG), 32'h1f0);
	endtask
	// Zone 2 factor 7 halves both banks, variants gate changes
	task automatic t_zone;
		logic [31:0] q;
		logic e;
		wr(REG_SCALE, 32'hfffff7ff);
		wr(REG_AMB_CTRL, 32'h1);
		prog(0, 9'h1f8, 8'h7f, 8'h00, 8'h40, 8'hff);
		prog(3, 9'h1f8, 8'h7f, 8'h00, 8'h40, 8'hff);
		strobe(3'h2, 3);
		apb(1'b0, REG_STATUS, 32'h0, q, e);
		`CHK("zone_direct", 3'h2, q[6:4])
		`CHK("run_banks", 4'h9, q[3:0])
		`CHK("scaled_b0", 16'h2020, SINK_LEVEL[0])
		`CHK("scaled_b3", 16'h2020, SINK_LEVEL[3])
		`CHK("no_int_pin", 1'b1, irq_line)
		wr(REG_AMB_CTRL, 32'h3);
		strobe(3'h1, 4);
		apb(1'b0, REG_STATUS, 32'h0, q, e);
		`CHK("zone_uponly", 3'h2, q[6:4])
		wr(REG_AMB_CTRL, 32'h5);
		strobe(3'h2, 1);
		strobe(3'h1, 5);
		apb(1'b0, REG_STATUS, 32'h0, q, e);
		`CHK("zone_dd5", 3'h2, q[6:4])
		strobe(3'h1, 1);
		apb(1'b0, REG_STATUS, 32'h0, q, e);
		`CHK("zone_dd6", 3'h1, q[6:4])
		`CHK("full_scale", 16'h4040, SINK_LEVEL[0])
		wr(ba(0, BK_CFG), 32'h1f0);
		wr(ba(3, BK_CFG), 32'h1f0);
	endtask
	task automatic t_irq;
		logic [31:0] q;
		logic e;
		apb(1'b0, REG_ZONE_INFO, 32'h0, q, e);
		`CHK("flag_set", 1'b1, q[ZI_FLAG])
		wr(REG_ZONE_INFO, 32'h1);
		repeat (2) @(posedge CLK);
		`CHK("pin_clear", 1'b1, irq_line)
		strobe(3'h4, 1);
		`CHK("pin_low", 1'b0, irq_line)
		apb(1'b0, REG_ZONE_INFO, 32'h0, q, e);
		`CHK("int_mode", 1'b1, q[0])
		repeat (2) @(posedge CLK);
		`CHK("pin_freed", 1'b1, irq_line)
		wr(REG_AMB_CTRL, 32'h0);
		strobe(3'h6, 1);
		`CHK("amb_off", 1'b1, irq_line)
		wr(REG_ZONE_INFO, 32'h0);
		wr(REG_AMB_CTRL, 32'h1);
		strobe(3'h3, 1);
		`CHK("mode_off", 1'b1, irq_line)
	endtask
	// ----
	// Verdict, watchdog and main sequence
	// ----
	task automatic end_sim;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge CLK);
		err_count++;
		end_sim();
	end
	initial begin
		CLK = 1'b0;
		NRST = 1'b0;
		PSEL = 1'b0;
		PENABLE = 1'b0;
		PWRITE = 1'b0;
		PADDR = 12'h000;
		PWDATA = 32'h0;
		ZONE_STROBE = 1'b0;
		ZONE = 3'h0;
		PWM_DUTY = 8'h80;
		err_count = 0;
		check_count = 0;
		repeat (12) @(posedge CLK);
		NRST <= 1'b1;
		t_reset();
		t_linear();
		t_pwm();
		t_exp();
		t_zone();
		t_irq();
		end_sim();
	end
endmodule
`default_nettype wire
